// ===== fic_pkg.sv
// package: constants and types of the flash page-load host controller
`default_nettype none
package fic_pkg;
  // clock and bus-cycle timing
  localparam int CLK_PERIOD_NS    = 8;
  localparam int ACCESS_NS        = 120;
  localparam int ACCESS_CYCLES    = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_PULSE_NS      = 60;
  localparam int WE_PULSE_CYCLES  = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] ACCESS_COUNT = 5'(ACCESS_CYCLES - 1);
  localparam logic [4:0] WE_COUNT     = 5'(WE_PULSE_CYCLES - 1);
  // page-load window, measured from the end of the previous load cycle
  localparam int LOAD_GAP_US      = 30;
  localparam int LOAD_GAP_CYCLES  = LOAD_GAP_US * 1000 / CLK_PERIOD_NS;
  // lead covers done-to-gap-clear plus accept-to-falling-strobe latency,
  // so the next falling strobe never lands later than the window allows
  localparam int LOAD_LEAD_CYCLES = 5;
  localparam logic [11:0] LOAD_GAP_LIMIT = 12'(LOAD_GAP_CYCLES - LOAD_LEAD_CYCLES);
  localparam logic [7:0] PAGE_BYTES = 8'h80;
  localparam logic [7:0] PAGE_WORDS = 8'h40;
  // command interface addresses and codes
  localparam logic [18:0] UNLOCK1_ADDR = 19'h05555;
  localparam logic [18:0] UNLOCK2_ADDR = 19'h02AAA;
  localparam logic [7:0]  CMD_UNLOCK1  = 8'hAA;
  localparam logic [7:0]  CMD_UNLOCK2  = 8'h55;
  localparam logic [7:0]  CMD_ID_READ  = 8'h90;
  localparam logic [7:0]  CMD_PROGRAM  = 8'hA0;
  localparam logic [7:0]  CMD_RESET    = 8'hF0;
  localparam logic [7:0]  CMD_RD_STAT  = 8'h70;
  localparam logic [7:0]  CMD_CLR_STAT = 8'h50;
  localparam logic [7:0]  LOAD_END_DATA = 8'h00;
  localparam int SR_READY_POS = 7;
  localparam int SR_FAIL_POS  = 4;
  // register map (byte offsets on APB)
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_ADDR  = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STAT  = 8'h10;
  localparam int CTRL_BYTE_BIT  = 8;
  localparam int CTRL_HV_BIT    = 9;
  localparam int STAT_BUSY      = 0;
  localparam int STAT_LOADING   = 1;
  localparam int STAT_REFUSED   = 2;
  localparam int STAT_LAPSED    = 3;
  localparam int STAT_READY     = 4;
  localparam int STAT_FAIL      = 5;
  localparam int STAT_COUNT_LSB = 8;
  localparam logic [3:0] OP_LAST_CODE = 4'h8;

  typedef enum logic [3:0] {
    OP_NONE         = 4'h0,
    OP_ARRAY_READ   = 4'h1,
    OP_RESET        = 4'h2,
    OP_ID_ENTER     = 4'h3,
    OP_PROG_START   = 4'h4,
    OP_LOAD         = 4'h5,
    OP_LOAD_END     = 4'h6,
    OP_STATUS_READ  = 4'h7,
    OP_STATUS_CLEAR = 4'h8
  } fic_op_type;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_UNLOCK1 = 3'b001,
    ST_UNLOCK2 = 3'b011,
    ST_COMMAND = 3'b010,
    ST_FINAL   = 3'b110
  } fic_state_type;

  typedef enum logic [1:0] {
    CY_IDLE   = 2'b00,
    CY_SETUP  = 2'b01,
    CY_STROBE = 2'b11,
    CY_HOLD   = 2'b10
  } fic_cycle_type;
endpackage
`default_nettype wire

// ===== fic_bus_cycle.sv
// one read or write cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
module fic_bus_cycle
  import fic_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic        write,
  input  wire logic [18:0] addr,
  input  wire logic        addr_lsb,
  input  wire logic [15:0] wdata,
  input  wire logic [15:0] dq_in,
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic [18:0]      addr_out,
  output logic             addr_lsb_out,
  output logic [15:0]      dq_out,
  output logic             dq_oe,
  output logic             done,
  output logic [15:0]      rdata
);
  fic_cycle_type phase_reg;
  logic [4:0]    count_reg;
  logic          write_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      phase_reg    <= CY_IDLE;
      count_reg    <= 5'h00;
      write_reg    <= 1'b0;
      ce_n         <= 1'b1;
      oe_n         <= 1'b1;
      we_n         <= 1'b1;
      addr_out     <= 19'h00000;
      addr_lsb_out <= 1'b0;
      dq_out       <= 16'h0000;
      dq_oe        <= 1'b0;
      done         <= 1'b0;
      rdata        <= 16'h0000;
    end else begin
      done <= 1'b0;
      unique case (phase_reg)
        CY_IDLE: if (start) begin
          // address settles with chip select, so the strobe falls last
          phase_reg    <= CY_SETUP;
          write_reg    <= write;
          addr_out     <= addr;
          addr_lsb_out <= addr_lsb;
          dq_out       <= wdata;
          dq_oe        <= write;
          ce_n         <= 1'b0;
        end
        CY_SETUP: begin
          phase_reg <= CY_STROBE;
          we_n      <= !write_reg;
          oe_n      <= write_reg;
          count_reg <= write_reg ? WE_COUNT : ACCESS_COUNT;
        end
        CY_STROBE: begin
          if (count_reg == 5'h00) begin
            phase_reg <= CY_HOLD;
            we_n      <= 1'b1;
            oe_n      <= 1'b1;
            if (!write_reg) begin
              rdata <= dq_in;
            end
          end else begin
            count_reg <= count_reg - 5'h01;
          end
        end
        CY_HOLD: begin
          // data stays driven past the rising write strobe for hold time
          phase_reg <= CY_IDLE;
          ce_n      <= 1'b1;
          dq_oe     <= 1'b0;
          done      <= 1'b1;
        end
      endcase
    end
  end

  property p_load_strobe;
    @(posedge clk) disable iff (reset)
      !we_n |-> (oe_n && !ce_n && dq_oe);
  endproperty
  a_load_strobe: assert property (p_load_strobe) else $error("write strobe without ce low, oe high");

  property p_read_float;
    @(posedge clk) disable iff (reset)
      !oe_n |-> (!dq_oe && !ce_n && we_n);
  endproperty
  a_read_float: assert property (p_read_float) else $error("host drives data during a read");

  property p_we_width;
    @(posedge clk) disable iff (reset)
      $fell(we_n) |-> (!we_n) [*8] ##1 we_n;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe width wrong");
endmodule
`default_nettype wire

// ===== fic_flash_host.sv
// host controller: APB registers driving a parallel flash command interface
// Functional notes
// - ID by high voltage: only A0, A1 decoded
// - ID mode held until read/reset written
// - program needs two unlocks then A0
// - load strobe: address on fall, data rise
// - page address A6-A18 fixed, any order
// - next load within 30 us
// - same address twice, second data zero, ends
// - clear status after checking result
// - erase sector before programming page (no erase op here; left to software)
// - unlock AA at 5555, 55 at 2AAA
`timescale 1ns/1ps
`default_nettype none
module fic_flash_host
  import fic_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n,
  output logic [18:0]      flash_addr,
  output logic             flash_addr_lsb,
  output logic [15:0]      flash_dq_out,
  output logic             flash_dq_oe,
  input  wire logic [15:0] flash_dq_in,
  output logic             flash_byte_n,
  output logic             id_high_voltage
);
  fic_state_type state_reg;
  fic_op_type    op_reg;
  fic_op_type    new_op;
  logic          issued_reg;
  logic          byte_mode_reg;
  logic [19:0]   addr_reg;
  logic [15:0]   wdata_reg;
  logic [15:0]   rdata_reg;
  logic          loading_reg;
  logic          load_byte_reg;
  logic [7:0]    load_count_reg;
  logic [12:0]   page_reg;
  logic [19:0]   last_addr_reg;
  logic [11:0]   gap_reg;
  logic          refused_reg;
  logic          lapsed_reg;
  logic          ready_reg;
  logic          fail_reg;
  logic          cyc_start;
  logic          cyc_write;
  logic [18:0]   cyc_addr;
  logic          cyc_lsb;
  logic [15:0]   cyc_data;
  logic          cyc_done;
  logic [15:0]   cyc_rdata;
  logic          step_write;
  logic [19:0]   step_addr;
  logic [15:0]   step_data;
  logic          op_refuse;
  logic [7:0]    load_limit;
  logic [31:0]   read_mux;
  logic          apb_take;
  logic          ctrl_wr;
  logic          op_go;
  logic          op_bad;

  function automatic logic reg_known(input logic [7:0] a);
    return a inside {REG_CTRL, REG_ADDR, REG_WDATA, REG_RDATA, REG_STAT};
  endfunction

  function automatic logic needs_unlock(input fic_op_type op);
    return op inside {OP_ID_ENTER, OP_PROG_START, OP_STATUS_READ, OP_STATUS_CLEAR};
  endfunction

  function automatic logic has_final(input fic_op_type op);
    return !(op inside {OP_ID_ENTER, OP_PROG_START, OP_STATUS_CLEAR});
  endfunction

  // ---- APB slave: one wait state, then answer
  assign apb_take = psel && penable && pready;
  assign ctrl_wr  = apb_take && pwrite && (paddr == REG_CTRL);
  assign new_op   = fic_op_type'(pwdata[3:0]);
  assign load_limit = load_byte_reg ? PAGE_BYTES : PAGE_WORDS;

  always_comb begin
    read_mux = 32'h00000000;
    unique case (paddr)
      REG_CTRL:  read_mux = {22'h000000, id_high_voltage, byte_mode_reg, 8'h00};
      REG_ADDR:  read_mux = {12'h000, addr_reg};
      REG_WDATA: read_mux = {16'h0000, wdata_reg};
      REG_RDATA: read_mux = {16'h0000, rdata_reg};
      REG_STAT:  read_mux = {16'h0000, load_count_reg, 2'b00, fail_reg, ready_reg,
                             lapsed_reg, refused_reg, loading_reg, state_reg != ST_IDLE};
      default:   read_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        pslverr <= !reg_known(paddr);
        prdata  <= pwrite ? 32'h00000000 : read_mux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      addr_reg  <= 20'h00000;
      wdata_reg <= 16'h0000;
    end else if (apb_take && pwrite) begin
      if (paddr == REG_ADDR) begin
        addr_reg <= pwdata[19:0];
      end
      if (paddr == REG_WDATA) begin
        wdata_reg <= pwdata[15:0];
      end
    end
  end

  // width and voltage bits freeze while a load period is open, so the
  // width pin seen at the third command write also covers every load
  always_ff @(posedge clk) begin
    if (reset) begin
      byte_mode_reg   <= 1'b0;
      id_high_voltage <= 1'b0;
      flash_byte_n    <= 1'b1;
    end else begin
      if (ctrl_wr && state_reg == ST_IDLE && !loading_reg) begin
        byte_mode_reg   <= pwdata[CTRL_BYTE_BIT];
        id_high_voltage <= pwdata[CTRL_HV_BIT];
      end
      flash_byte_n <= !byte_mode_reg;
    end
  end

  // ---- order checks: refused orders never start a flash bus cycle
  always_comb begin
    op_bad    = pwdata[3:0] > OP_LAST_CODE;
    op_refuse = 1'b0;
    if (state_reg != ST_IDLE || op_bad) begin
      op_refuse = 1'b1;
    end else if (pwdata[CTRL_HV_BIT] && new_op != OP_ARRAY_READ) begin
      op_refuse = 1'b1;
    end else begin
      unique case (new_op)
        OP_LOAD:
          op_refuse = !loading_reg || load_count_reg >= load_limit
                      || gap_reg >= LOAD_GAP_LIMIT
                      || (load_count_reg != 8'h00 && addr_reg[18:6] != page_reg);
        OP_LOAD_END:
          op_refuse = !loading_reg || load_count_reg == 8'h00 || gap_reg >= LOAD_GAP_LIMIT;
        // any other write in a load period would be taken as page data
        default:
          op_refuse = loading_reg;
      endcase
    end
  end

  assign op_go = ctrl_wr && pwdata[3:0] != 4'h0 && !op_refuse;

  // ---- command sequencer
  always_comb begin
    step_write = 1'b1;
    step_addr  = {1'b0, UNLOCK1_ADDR};
    step_data  = 16'h0000;
    unique case (state_reg)
      ST_UNLOCK1: step_data = {8'h00, CMD_UNLOCK1};
      ST_UNLOCK2: begin
        step_addr = {1'b0, UNLOCK2_ADDR};
        step_data = {8'h00, CMD_UNLOCK2};
      end
      ST_COMMAND: begin
        unique case (op_reg)
          OP_ID_ENTER:    step_data = {8'h00, CMD_ID_READ};
          OP_PROG_START:  step_data = {8'h00, CMD_PROGRAM};
          OP_STATUS_READ: step_data = {8'h00, CMD_RD_STAT};
          default:        step_data = {8'h00, CMD_CLR_STAT};
        endcase
      end
      ST_FINAL: begin
        step_write = op_reg inside {OP_RESET, OP_LOAD, OP_LOAD_END};
        step_addr  = addr_reg;
        if (id_high_voltage) begin
          step_addr = {18'h00000, addr_reg[1:0]};
        end
        unique case (op_reg)
          OP_RESET:    step_data = {8'h00, CMD_RESET};
          OP_LOAD:     step_data = load_byte_reg ? {8'h00, wdata_reg[7:0]} : wdata_reg;
          OP_LOAD_END: begin
            step_addr = last_addr_reg;
            step_data = {8'h00, LOAD_END_DATA};
          end
          default:     step_data = 16'h0000;
        endcase
      end
      default: step_write = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg  <= ST_IDLE;
      op_reg     <= OP_NONE;
      issued_reg <= 1'b0;
      cyc_start  <= 1'b0;
      cyc_write  <= 1'b0;
      cyc_addr   <= 19'h00000;
      cyc_lsb    <= 1'b0;
      cyc_data   <= 16'h0000;
    end else begin
      cyc_start <= 1'b0;
      if (state_reg == ST_IDLE) begin
        if (op_go) begin
          op_reg    <= new_op;
          state_reg <= needs_unlock(new_op) ? ST_UNLOCK1 : ST_FINAL;
        end
      end else if (!issued_reg) begin
        issued_reg <= 1'b1;
        cyc_start  <= 1'b1;
        cyc_write  <= step_write;
        cyc_addr   <= step_addr[18:0];
        cyc_lsb    <= step_addr[19];
        cyc_data   <= step_data;
      end else if (cyc_done) begin
        issued_reg <= 1'b0;
        unique case (state_reg)
          ST_UNLOCK1: state_reg <= ST_UNLOCK2;
          ST_UNLOCK2: state_reg <= ST_COMMAND;
          ST_COMMAND: state_reg <= has_final(op_reg) ? ST_FINAL : ST_IDLE;
          default:    state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // ---- load period bookkeeping
  always_ff @(posedge clk) begin
    if (reset) begin
      loading_reg    <= 1'b0;
      load_byte_reg  <= 1'b0;
      load_count_reg <= 8'h00;
      page_reg       <= 13'h0000;
      last_addr_reg  <= 20'h00000;
      gap_reg        <= 12'h000;
    end else begin
      if (loading_reg && gap_reg != LOAD_GAP_LIMIT) begin
        gap_reg <= gap_reg + 12'h001;
      end
      if (state_reg == ST_COMMAND && cyc_done && op_reg == OP_PROG_START) begin
        // no erase op here: software must erase the sector before this
        loading_reg    <= 1'b1;
        load_byte_reg  <= byte_mode_reg;
        load_count_reg <= 8'h00;
        gap_reg        <= 12'h000;
      end else if (state_reg == ST_FINAL && cyc_done && op_reg == OP_LOAD) begin
        load_count_reg <= load_count_reg + 8'h01;
        page_reg       <= cyc_addr[18:6];
        last_addr_reg  <= {cyc_lsb, cyc_addr};
        gap_reg        <= 12'h000;
      end else if (state_reg == ST_FINAL && cyc_done && op_reg == OP_LOAD_END) begin
        loading_reg <= 1'b0;
      end else if (loading_reg && state_reg == ST_IDLE && gap_reg == LOAD_GAP_LIMIT) begin
        loading_reg <= 1'b0;
      end
    end
  end

  // ---- read results and sticky flags; a new event wins over its clear
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_reg   <= 16'h0000;
      ready_reg   <= 1'b0;
      fail_reg    <= 1'b0;
      refused_reg <= 1'b0;
      lapsed_reg  <= 1'b0;
    end else begin
      if (state_reg == ST_FINAL && cyc_done && !cyc_write) begin
        rdata_reg <= load_byte_reg || byte_mode_reg ? {8'h00, cyc_rdata[7:0]} : cyc_rdata;
        if (op_reg == OP_STATUS_READ) begin
          ready_reg <= cyc_rdata[SR_READY_POS];
          fail_reg  <= cyc_rdata[SR_FAIL_POS];
        end
      end
      if (ctrl_wr && pwdata[3:0] != 4'h0 && op_refuse) begin
        refused_reg <= 1'b1;
      end else if (apb_take && pwrite && paddr == REG_STAT && pwdata[STAT_REFUSED]) begin
        refused_reg <= 1'b0;
      end
      if (loading_reg && state_reg == ST_IDLE && gap_reg == LOAD_GAP_LIMIT) begin
        lapsed_reg <= 1'b1;
      end else if (apb_take && pwrite && paddr == REG_STAT && pwdata[STAT_LAPSED]) begin
        lapsed_reg <= 1'b0;
      end
    end
  end

  fic_bus_cycle u_cycle (
    .clk          (clk),
    .reset        (reset),
    .start        (cyc_start),
    .write        (cyc_write),
    .addr         (cyc_addr),
    .addr_lsb     (cyc_lsb),
    .wdata        (cyc_data),
    .dq_in        (flash_dq_in),
    .ce_n         (flash_ce_n),
    .oe_n         (flash_oe_n),
    .we_n         (flash_we_n),
    .addr_out     (flash_addr),
    .addr_lsb_out (flash_addr_lsb),
    .dq_out       (flash_dq_out),
    .dq_oe        (flash_dq_oe),
    .done         (cyc_done),
    .rdata        (cyc_rdata)
  );

  property p_unlock1;
    @(posedge clk) disable iff (reset)
      (cyc_start && state_reg == ST_UNLOCK1) |-> (cyc_write && cyc_addr[14:0] == 15'h5555
        && cyc_data[7:0] == 8'hAA);
  endproperty
  a_unlock1: assert property (p_unlock1) else $error("first unlock write wrong");

  property p_program_code;
    @(posedge clk) disable iff (reset)
      (cyc_start && state_reg == ST_COMMAND && op_reg == OP_PROG_START)
        |-> (cyc_data[7:0] == 8'hA0 && cyc_addr[14:0] == 15'h5555);
  endproperty
  a_program_code: assert property (p_program_code) else $error("program command wrong");

  property p_cmd_upper;
    @(posedge clk) disable iff (reset)
      (cyc_start && state_reg != ST_FINAL) |-> cyc_data[15:8] == 8'h00;
  endproperty
  a_cmd_upper: assert property (p_cmd_upper) else $error("command upper byte not zero");

  property p_load_limit;
    @(posedge clk) disable iff (reset)
      loading_reg |-> load_count_reg <= (load_byte_reg ? 8'h80 : 8'h40);
  endproperty
  a_load_limit: assert property (p_load_limit) else $error("too many page loads");

  property p_page_match;
    @(posedge clk) disable iff (reset)
      (cyc_start && state_reg == ST_FINAL && op_reg == OP_LOAD && load_count_reg != 8'h00)
        |-> cyc_addr[18:6] == page_reg;
  endproperty
  a_page_match: assert property (p_page_match) else $error("load left its page");

  property p_end_zero;
    @(posedge clk) disable iff (reset)
      (cyc_start && state_reg == ST_FINAL && op_reg == OP_LOAD_END)
        |-> (cyc_data == 16'h0000 && {cyc_lsb, cyc_addr} == last_addr_reg) ##1 loading_reg;
  endproperty
  a_end_zero: assert property (p_end_zero) else $error("load end write wrong");

  property p_window_close;
    @(posedge clk) disable iff (reset)
      (loading_reg && state_reg == ST_IDLE && gap_reg == LOAD_GAP_LIMIT)
        |=> (!loading_reg && lapsed_reg);
  endproperty
  a_window_close: assert property (p_window_close) else $error("lapsed window kept open");

  property p_no_reset_loading;
    @(posedge clk) disable iff (reset)
      (ctrl_wr && new_op == OP_RESET && loading_reg && state_reg == ST_IDLE)
        |=> (state_reg == ST_IDLE && refused_reg);
  endproperty
  a_no_reset_loading: assert property (p_no_reset_loading) else $error("reset sent in load");

  property p_hv_addr;
    @(posedge clk) disable iff (reset)
      (id_high_voltage && !flash_ce_n) |-> flash_addr[18:2] == 17'h00000;
  endproperty
  a_hv_addr: assert property (p_hv_addr) else $error("high address bits in voltage ID mode");

  property p_status_capture;
    @(posedge clk) disable iff (reset)
      (cyc_done && state_reg == ST_FINAL && op_reg == OP_STATUS_READ)
        |=> (ready_reg == $past(cyc_rdata[7]) && fail_reg == $past(cyc_rdata[4]));
  endproperty
  a_status_capture: assert property (p_status_capture) else $error("status bits not captured");

  property p_width_latch;
    @(posedge clk) disable iff (reset)
      $rose(loading_reg) |-> (load_byte_reg == !flash_byte_n);
  endproperty
  a_width_latch: assert property (p_width_latch) else $error("width pin differs from load width");
endmodule
`default_nettype wire

// ===== fic_flash_model.sv
// behavioural flash device answering the host controller's pin cycles
`timescale 1ns/1ps
`default_nettype none
module fic_flash_model
  import fic_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] DEV_CODE   = 8'h3C  // arbitrary value
) (
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [18:0] addr,
  input  wire logic [15:0] dq_host,
  input  wire logic        byte_n,
  input  wire logic        hv,
  output logic      [15:0] dq
);
  logic [15:0] mem [logic [18:0]];
  logic [18:0] la, ll;
  logic [7:0]  d;
  logic [15:0] held = 16'hA5A5;
  bit          idm, stm, ld, busy, fail;
  int          step;
  realtime     tl;
  event        go;
  function automatic logic [15:0] rv(input logic [18:0] a);
    logic [15:0] v;
    if (hv || idm) v = {8'h00, a[0] ? DEV_CODE : MAKER_CODE};
    else if (stm) v = {8'h00, !busy, 2'b00, fail, 4'h0};
    else v = mem.exists(a) ? mem[a] : 16'hFFFF;
    if ((hv || idm) && a[1]) v = 16'h0000;
    if (!byte_n) v[15:8] = 8'h00;
    return v;
  endfunction
  // released bus shows a toggling pattern, never a stale value
  always #8 held = ~held;
  assign dq = (!ce_n && !oe_n && we_n) ? rv(addr) : held;
  always @(negedge we_n) if (!ce_n) la = addr;
  always @(posedge we_n) if (!ce_n) begin
    d = dq_host[7:0];
    if (ld && la == ll && dq_host == 16'h0000) begin
      ld = 0;
      ->go;
    end else if (ld) begin
      mem[la] = dq_host;
      ll = la;
      tl = $realtime;
    end else if (d == 8'hF0) begin
      if (!busy) begin
        idm = 0;
        stm = 0;
      end
      step = 0;
    end else if (step == 0 && la[14:0] == 15'h5555 && d == 8'hAA) step = 1;
    else if (step == 1 && la[14:0] == 15'h2AAA && d == 8'h55) step = 2;
    else if (step == 2 && la[14:0] == 15'h5555) begin
      step = 0;
      idm = d == 8'h90;
      stm = d == 8'h70;
      ld = d == 8'hA0;
      ll = 19'h7FFFF;
      tl = $realtime;
      if (d == 8'h50) fail = 0;
    end else step = 0;
  end
  always #1000 if (ld && $realtime - tl >= 100000.0) begin
    ld = 0;
    ->go;
  end
  always @(go) begin
    busy = 1;
    #5000;
    busy = 0;
  end
endmodule
`default_nettype wire

// ===== fic_flash_host_tb.sv
// self-checking bench for the flash page-load host controller
`timescale 1ns/1ps
`default_nettype none
module fic_flash_host_tb
  import fic_pkg::*;
;
  localparam logic [7:0] MK = 8'h5A;
  localparam logic [7:0] DV = 8'h3C;
  logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, ce_n, oe_n, we_n, dq_oe, byte_n, hv, a_lsb, r_err;
  logic [18:0] fa;
  logic [15:0] dq_o, dq_i;
  int          n_mismatch = 0, comparisons = 0;
  always #4 clk = ~clk;
  fic_flash_host dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_addr(fa), .flash_addr_lsb(a_lsb), .flash_dq_out(dq_o), .flash_dq_oe(dq_oe),
    .flash_dq_in(dq_i), .flash_byte_n(byte_n), .id_high_voltage(hv));
  fic_flash_model #(.MAKER_CODE(MK), .DEV_CODE(DV)) fm (.ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .addr(fa), .dq_host(dq_oe ? dq_o : ~dq_o), .byte_n(byte_n), .hv(hv),
    .dq(dq_i));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    r_err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  // leaves the final status word in r
  task automatic op(input logic [31:0] c, input logic [19:0] a, input logic [15:0] dat);
    apb(1'b1, REG_ADDR, 32'(a));
    apb(1'b1, REG_WDATA, 32'(dat));
    apb(1'b1, REG_CTRL, c);
    do apb(1'b0, REG_STAT, 32'h0); while (r[STAT_BUSY] !== 1'b0);
  endtask
  task automatic rd(input logic [19:0] a);
    op(32'h1, a, 16'h0000);
    apb(1'b0, REG_RDATA, 32'h0);
  endtask
  task automatic t_id;
    op(32'h3, 20'h0, 16'h0000);
    rd(20'h0); chk(r, {24'h0, MK});
    rd(20'h1); chk(r, {24'h0, DV});
    rd(20'h2); chk(r, 32'h0);
    op(32'h2, 20'h0, 16'h0000);
    rd(20'h0); chk(r, 32'h0000FFFF);
    op(32'h201, 20'h1, 16'h0000); apb(1'b0, REG_RDATA, 32'h0); chk(r, {24'h0, DV});
    apb(1'b1, REG_CTRL, 32'h0);
    apb(1'b0, 8'h14, 32'h0); chk({r[31:1], r_err}, 32'h1);
  endtask
  task automatic t_prog;
    op(32'h4, 20'h0, 16'h0000);
    op(32'h5, 20'h00101, 16'h1234);
    op(32'h5, 20'h00100, 16'h5678);
    op(32'h5, 20'h00200, 16'h9999); chk(r[3:0], 32'h6);
    apb(1'b1, REG_STAT, 32'h4);
    op(32'h6, 20'h00100, 16'h0000);
    op(32'h7, 20'h0, 16'h0000); chk(r[5:4], 32'h0);
    repeat (1500) @(posedge clk);
    op(32'h7, 20'h0, 16'h0000); chk(r[5:4], 32'h1);
    op(32'h8, 20'h0, 16'h0000);
    op(32'h2, 20'h0, 16'h0000);
    rd(20'h00101); chk(r, 32'h1234);
    rd(20'h00102); chk(r, 32'hFFFF);
  endtask
  task automatic t_lapse;
    op(32'h4, 20'h0, 16'h0000);
    op(32'h5, 20'h00300, 16'hABCD);
    repeat (3800) @(posedge clk);
    apb(1'b0, REG_STAT, 32'h0); chk(r[3:1], 32'h4);
    apb(1'b1, REG_STAT, 32'h8);
    repeat (13500) @(posedge clk);
    rd(20'h00300); chk(r, 32'hABCD);
  endtask
  // fills one word page, then tries one load and a read/reset too many
  task automatic t_limit;
    op(32'h4, 20'h0, 16'h0000);
    for (int i = 0; i < 64; i++) op(32'h5, 20'h00400 + 20'(i), 16'(i));
    op(32'h5, 20'h00410, 16'h0001); chk({r[15:8], r[3:0]}, 32'h406);
    apb(1'b1, REG_STAT, 32'h4);
    op(32'h2, 20'h0, 16'h0000); chk(r[3:0], 32'h6);
    apb(1'b1, REG_STAT, 32'h4);
    op(32'h6, 20'h0, 16'h0000); chk(r[1:0], 32'h0);
    repeat (700) @(posedge clk);
  endtask
  // byte-wide load with the half-word lane bit set; word read sees upper byte zero
  task automatic t_byte;
    op(32'h104, 20'h0, 16'h0000);
    op(32'h105, 20'h80500, 16'h77CC); chk({r[15:8], 7'h0, a_lsb}, 32'h101);
    op(32'h106, 20'h0, 16'h0000);
    repeat (700) @(posedge clk);
    op(32'h101, 20'h80500, 16'h0000); apb(1'b0, REG_RDATA, 32'h0); chk(r, 32'h00CC);
    rd(20'h00500); chk(r, 32'h00CC);
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    rd(20'h00100); chk(r, 32'h0000FFFF);
    t_id;
    t_prog;
    t_lapse;
    t_limit;
    t_byte;
    tally_and_finish;
  end
endmodule
`default_nettype wire
